// >>> core/acs_pkg.sv
// Constants and enumerations for the converter conversion sequencer.
// Assumes a single 200 MHz system clock; all times are turned into cycles here.
package acs_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS    = 5;
  localparam int POR_TIME_NS      = 4000000;
  localparam int POR_CYC          = POR_TIME_NS / CLK_PERIOD_NS;
  localparam int CONV_INT_TIME_NS = 147000000;
  localparam int CONV_INT_CYC     = CONV_INT_TIME_NS / CLK_PERIOD_NS;
  localparam int EXT_MIN_FREQ_HZ  = 10000;
  localparam int EXT_MAX_PER_NS   = 1000000000 / EXT_MIN_FREQ_HZ;
  // Must exceed the slowest legal external period
  localparam int EXT_TMO_CYC      = EXT_MAX_PER_NS / CLK_PERIOD_NS + 1;
  localparam int CONV_EXT_PER     = 41036;
  localparam int DEC_EXT_PER      = 5120;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int POR_W    = 20;
  localparam int CONV_W   = 25;
  localparam int TMO_W    = 16;
  localparam int DEC_W    = 13;
  localparam int RES_BITS = 24;
  localparam int SYNC_W   = 7;

  // ****************************************************************
  // Serial protocol
  // ****************************************************************
  localparam logic [4:0] RES_LAST_BIT = 5'h17;
  localparam logic [2:0] BYTE_LAST    = 3'h7;
  localparam logic       RW_READ      = 1'b1;

  // ****************************************************************
  // Strap levels and slave addresses
  // ****************************************************************
  localparam logic [1:0] LVL_LOW   = 2'h0;
  localparam logic [1:0] LVL_HIGH  = 2'h1;
  localparam logic [1:0] LVL_FLOAT = 2'h2;
  localparam logic [6:0] ADDR_LH   = 7'h14;
  localparam logic [6:0] ADDR_LF   = 7'h15;
  localparam logic [6:0] ADDR_FH   = 7'h17;
  localparam logic [6:0] ADDR_FF   = 7'h24;
  localparam logic [6:0] ADDR_HH   = 7'h26;
  localparam logic [6:0] ADDR_HF   = 7'h27;

  // ****************************************************************
  // State encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    ACS_POR   = 2'b00,
    ACS_CONV  = 2'b01,
    ACS_SLEEP = 2'b10,
    ACS_OUT   = 2'b11
  } acs_seq_t;

  typedef enum logic [2:0] {
    ACS_IDLE  = 3'b000,
    ACS_ADDR  = 3'b001,
    ACS_AWAIT = 3'b010,
    ACS_AACK  = 3'b011,
    ACS_TX    = 3'b100,
    ACS_MACK  = 3'b101
  } acs_i2c_t;

endpackage

// >>> core/acs_sync.sv
// Two flip-flop synchroniser for a group of asynchronous pins.
// Assumes each bit is independent; no word coherence is promised.
`timescale 1ns/1ps
`default_nettype none

module acs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         arst_n_i,
  // Pins in, synchronised out
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } acs_sync_st_t;

  acs_sync_st_t q;
  acs_sync_st_t d;

  // First stage feeds only the second stage
  always_comb begin
    d.meta = async_i;
    d.sync = q.meta;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_o = q.sync;

endmodule // acs_sync

`default_nettype wire

// >>> core/acs_sequencer.sv
// Conversion, sleep and output sequencer with a read-only two-wire slave port.
// Assumes conv_result_i is the filter output on sys_clk; all pins arrive async.
`timescale 1ns/1ps
`default_nettype none

module acs_sequencer #(
  parameter int POR_CYC      = acs_pkg::POR_CYC,
  parameter int CONV_INT_CYC = acs_pkg::CONV_INT_CYC,
  parameter int EXT_TMO_CYC  = acs_pkg::EXT_TMO_CYC
) (
  // Clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 arst_n_i,
  // Supply monitor
  input  wire logic                 supply_ok_i,
  // Two-wire bus
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe_n_o,
  // Address straps
  input  wire logic [1:0]           addr_strap_high_pin_i,
  input  wire logic                 addr_strap_low_clock_pin_i,
  input  wire logic                 addr_strap_low_float_i,
  // Converter core
  input  wire logic [23:0]          conv_result_i,
  output logic                      osc_enable_o,
  output logic [1:0]                seq_state_o,
  output logic                      cal_start_o,
  output logic                      dec_tick_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    acs_pkg::acs_seq_t            seq;
    acs_pkg::acs_i2c_t            i2c;
    logic [acs_pkg::POR_W-1:0]    por_cnt;
    logic [acs_pkg::CONV_W-1:0]   conv_cnt;
    logic [acs_pkg::TMO_W-1:0]    tmo_cnt;
    logic [acs_pkg::DEC_W-1:0]    dec_cnt;
    logic [4:0]                   tx_cnt;
    logic [2:0]                   bit_cnt;
    logic [7:0]                   addr_sh;
    logic [acs_pkg::RES_BITS-1:0] out_sh;
    logic                         ack_ok;
    logic                         edge_seen;
    logic                         ext_mode;
    logic                         osc_en;
    logic                         sda_oe_n;
    logic                         sda_lvl;
    logic                         cal_start;
    logic                         dec_tick;
    logic                         scl_p;
    logic                         sda_p;
    logic                         fclk_p;
  } acs_state_t;

  localparam acs_state_t ST_RST = '{seq: acs_pkg::ACS_POR, i2c: acs_pkg::ACS_IDLE,
                                    sda_oe_n: 1'b1, osc_en: 1'b1, default: '0};

  acs_state_t                   q;
  acs_state_t                   d;
  logic [acs_pkg::SYNC_W-1:0]   pins_s;
  logic                         scl;
  logic                         sda;
  logic                         fclk;
  logic                         sok;
  logic [1:0]                   hi_lvl;
  logic [1:0]                   lo_lvl;
  logic                         scl_rise;
  logic                         scl_fall;
  logic                         fclk_rise;
  logic                         start_det;
  logic                         stop_det;
  logic [7:0]                   own;
  logic [7:0]                   addr_byte;
  logic                         conv_done;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  acs_sync #(
    .W (acs_pkg::SYNC_W)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .async_i   ({addr_strap_high_pin_i, supply_ok_i, addr_strap_low_float_i,
                 addr_strap_low_clock_pin_i, sda_i, scl_i}),
    .sync_o    (pins_s)
  );

  assign scl    = pins_s[0];
  assign sda    = pins_s[1];
  assign fclk   = pins_s[2];
  assign sok    = pins_s[4];
  assign hi_lvl = pins_s[6:5];

  assign scl_rise  = scl & ~q.scl_p;
  assign scl_fall  = ~scl & q.scl_p;
  assign fclk_rise = fclk & ~q.fclk_p;
  assign start_det = q.scl_p & scl & q.sda_p & ~sda;
  assign stop_det  = q.scl_p & scl & ~q.sda_p & sda;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Low strap reads high while it carries the conversion clock
  assign lo_lvl = q.ext_mode ? acs_pkg::LVL_HIGH :
                  pins_s[3] ? acs_pkg::LVL_FLOAT :
                  fclk ? acs_pkg::LVL_HIGH : acs_pkg::LVL_LOW;

  // Bit 7 flags a legal strap pair; low/low pairs answer nothing
  function automatic logic [7:0] addr_lookup(input logic [1:0] h, input logic [1:0] l);
    case ({h, l})
      {acs_pkg::LVL_LOW, acs_pkg::LVL_HIGH}:     addr_lookup = {1'b1, acs_pkg::ADDR_LH};
      {acs_pkg::LVL_LOW, acs_pkg::LVL_FLOAT}:    addr_lookup = {1'b1, acs_pkg::ADDR_LF};
      {acs_pkg::LVL_FLOAT, acs_pkg::LVL_HIGH}:   addr_lookup = {1'b1, acs_pkg::ADDR_FH};
      {acs_pkg::LVL_FLOAT, acs_pkg::LVL_FLOAT}:  addr_lookup = {1'b1, acs_pkg::ADDR_FF};
      {acs_pkg::LVL_HIGH, acs_pkg::LVL_HIGH}:    addr_lookup = {1'b1, acs_pkg::ADDR_HH};
      {acs_pkg::LVL_HIGH, acs_pkg::LVL_FLOAT}:   addr_lookup = {1'b1, acs_pkg::ADDR_HF};
      default:                                   addr_lookup = 8'h00;
    endcase
  endfunction

  assign own       = addr_lookup(hi_lvl, lo_lvl);
  assign addr_byte = {q.addr_sh[6:0], sda};

  // Conversion ends after CONV_INT_CYC cycles, or after CONV_EXT_PER external clock edges in external mode
  assign conv_done = q.ext_mode ?
                     (fclk_rise && q.conv_cnt >= acs_pkg::CONV_W'(acs_pkg::CONV_EXT_PER - 1)) :
                     (q.conv_cnt >= acs_pkg::CONV_W'(CONV_INT_CYC - 1));

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    d           = q;
    d.cal_start = 1'b0;
    d.dec_tick  = 1'b0;
    d.scl_p     = scl;
    d.sda_p     = sda;
    d.fclk_p    = fclk;

    // Clock source: two edges inside the timeout select the external clock
    if (fclk_rise) begin
      d.tmo_cnt   = '0;
      d.edge_seen = 1'b1;
      if (q.edge_seen) begin
        d.ext_mode = 1'b1;
      end
    end else if (q.tmo_cnt >= acs_pkg::TMO_W'(EXT_TMO_CYC)) begin
      d.edge_seen = 1'b0;
      d.ext_mode  = 1'b0;
    end else begin
      d.tmo_cnt = q.tmo_cnt + 1'b1;
    end
    d.osc_en = ~d.ext_mode;

    // Filter frame strobe sets the notch at the external rate over 5120
    if (!q.ext_mode) begin
      d.dec_cnt = '0;
    end else if (fclk_rise) begin
      if (q.dec_cnt == acs_pkg::DEC_W'(acs_pkg::DEC_EXT_PER - 1)) begin
        d.dec_cnt  = '0;
        d.dec_tick = 1'b1;
      end else begin
        d.dec_cnt = q.dec_cnt + 1'b1;
      end
    end

    // Conversion sequence
    case (q.seq)
      acs_pkg::ACS_POR: begin
        if (q.por_cnt >= acs_pkg::POR_W'(POR_CYC - 1)) begin
          d.seq = acs_pkg::ACS_CONV;
        end else begin
          d.por_cnt = q.por_cnt + 1'b1;
        end
      end
      acs_pkg::ACS_CONV: begin
        // Counter keeps running across a source change: only this result suffers
        d.conv_cnt = q.conv_cnt + {24'h0, (~q.ext_mode | fclk_rise)};
        if (conv_done) begin
          d.seq    = acs_pkg::ACS_SLEEP;
          d.out_sh = conv_result_i;
          d.tx_cnt = '0;
        end
      end
      acs_pkg::ACS_SLEEP: begin
      end
      acs_pkg::ACS_OUT: begin
      end
      default: begin
        d.seq = acs_pkg::ACS_POR;
      end
    endcase

    // Two-wire slave
    if (start_det) begin
      d.i2c      = acs_pkg::ACS_ADDR;
      d.bit_cnt  = '0;
      d.sda_oe_n = 1'b1;
    end else if (stop_det) begin
      d.i2c      = acs_pkg::ACS_IDLE;
      d.sda_oe_n = 1'b1;
      if (q.seq == acs_pkg::ACS_OUT) begin
        d.seq = acs_pkg::ACS_CONV;
      end
    end else begin
      case (q.i2c)
        acs_pkg::ACS_IDLE: begin
        end
        acs_pkg::ACS_ADDR: begin
          if (scl_rise) begin
            d.addr_sh = addr_byte;
            d.bit_cnt = q.bit_cnt + 1'b1;
            if (q.bit_cnt == acs_pkg::BYTE_LAST) begin
              // Ack only a read while a result waits
              d.ack_ok = (addr_byte[0] == acs_pkg::RW_READ) &&
                         (q.seq == acs_pkg::ACS_SLEEP);
              d.i2c    = (own[7] && addr_byte[7:1] == own[6:0]) ?
                         acs_pkg::ACS_AWAIT : acs_pkg::ACS_IDLE;
            end
          end
        end
        acs_pkg::ACS_AWAIT: begin
          if (scl_fall) begin
            d.i2c      = acs_pkg::ACS_AACK;
            d.sda_oe_n = ~q.ack_ok;
            if (q.ack_ok) begin
              d.seq = acs_pkg::ACS_OUT;
            end
          end
        end
        acs_pkg::ACS_AACK: begin
          if (scl_fall) begin
            d.bit_cnt  = '0;
            d.i2c      = q.ack_ok ? acs_pkg::ACS_TX : acs_pkg::ACS_IDLE;
            d.sda_oe_n = q.ack_ok ? q.out_sh[23] : 1'b1;
          end
        end
        acs_pkg::ACS_TX: begin
          if (scl_fall) begin
            d.out_sh = {q.out_sh[22:0], 1'b0};
            d.tx_cnt = q.tx_cnt + 1'b1;
            d.bit_cnt = q.bit_cnt + 1'b1;
            if (q.bit_cnt == acs_pkg::BYTE_LAST) begin
              d.i2c      = acs_pkg::ACS_MACK;
              d.sda_oe_n = 1'b1;
              if (q.tx_cnt == acs_pkg::RES_LAST_BIT) begin
                d.seq = acs_pkg::ACS_CONV;
              end
            end else begin
              d.sda_oe_n = q.out_sh[22];
            end
          end
        end
        acs_pkg::ACS_MACK: begin
          if (scl_rise) begin
            d.ack_ok = ~sda;
          end
          if (scl_fall) begin
            d.bit_cnt = '0;
            if (q.ack_ok && q.seq == acs_pkg::ACS_OUT) begin
              d.i2c      = acs_pkg::ACS_TX;
              d.sda_oe_n = q.out_sh[23];
            end else begin
              d.i2c = acs_pkg::ACS_IDLE;
            end
          end
        end
        default: begin
          d.i2c = acs_pkg::ACS_IDLE;
        end
      endcase
    end

    // Every conversion opens with its own calibration, no extra state
    if (d.seq == acs_pkg::ACS_CONV && q.seq != acs_pkg::ACS_CONV) begin
      d.conv_cnt  = '0;
      d.cal_start = 1'b1;
    end

    // Supply loss clears everything and restarts the reset hold
    if (!sok) begin
      d = ST_RST;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  assign sda_o        = q.sda_lvl;
  assign sda_oe_n_o   = q.sda_oe_n;
  assign osc_enable_o = q.osc_en;
  assign seq_state_o  = q.seq;
  assign cal_start_o  = q.cal_start;
  assign dec_tick_o   = q.dec_tick;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  a_conv_to_sleep: assert property (
    (q.seq == acs_pkg::ACS_CONV && conv_done && sok) |=> q.seq == acs_pkg::ACS_SLEEP)
    else $error("conversion end did not enter sleep");
  a_ack_to_out: assert property (
    (q.seq == acs_pkg::ACS_OUT && $past(q.seq) == acs_pkg::ACS_SLEEP) |->
    (!q.sda_oe_n && q.i2c == acs_pkg::ACS_AACK))
    else $error("output state entered without acknowledge");
  a_stop_ends_out: assert property (
    (stop_det && q.seq == acs_pkg::ACS_OUT && sok) |=>
    (q.seq == acs_pkg::ACS_CONV && q.cal_start))
    else $error("stop did not start a conversion");
  a_ext_addr_high: assert property (
    (q.ext_mode && hi_lvl == acs_pkg::LVL_HIGH) |-> own == {1'b1, acs_pkg::ADDR_HH})
    else $error("clocked strap not read as high");
  a_busy_nak: assert property (
    (q.i2c == acs_pkg::ACS_AWAIT && q.seq == acs_pkg::ACS_CONV && scl_fall) |=>
    q.sda_oe_n [*2])
    else $error("slave pulled data low while converting");
  a_clock_loss: assert property (
    (q.ext_mode && !fclk_rise && q.tmo_cnt >= acs_pkg::TMO_W'(EXT_TMO_CYC)) |=>
    (!q.ext_mode ##1 q.osc_en))
    else $error("external clock loss not handled");
  a_int_conv_len: assert property (
    (q.seq == acs_pkg::ACS_CONV && !q.ext_mode && sok &&
     q.conv_cnt == acs_pkg::CONV_W'(CONV_INT_CYC - 1)) |=> q.seq == acs_pkg::ACS_SLEEP)
    else $error("internal conversion length wrong");
  a_dec_tick_ext: assert property (
    q.dec_tick |-> ($past(q.ext_mode) && $past(q.dec_cnt) ==
                    acs_pkg::DEC_W'(acs_pkg::DEC_EXT_PER - 1)))
    else $error("frame strobe outside external mode");
  a_cal_each_conv: assert property (
    $rose(q.seq == acs_pkg::ACS_CONV) |-> (q.cal_start && q.conv_cnt == '0))
    else $error("conversion began without calibration");
  a_por_hold: assert property (
    (q.seq == acs_pkg::ACS_POR && q.por_cnt < acs_pkg::POR_W'(POR_CYC - 1)) |=>
    q.seq == acs_pkg::ACS_POR)
    else $error("reset hold ended early");
  a_result_capture: assert property (
    $rose(q.seq == acs_pkg::ACS_SLEEP) |-> q.out_sh == $past(conv_result_i))
    else $error("result not captured at conversion end");

endmodule // acs_sequencer

`default_nettype wire

// >>> verification/acs_i2c_mst.sv
// Two-wire bus master model that reads results from the sequencer.
// Assumes the bench resolves SDA as an open-drain wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none

module acs_i2c_mst (
  // Clock
  input  wire logic sys_clk_i,
  // Bus
  input  wire logic sda_i,
  output var logic  scl_o,
  output var logic  sda_o
);
  // ****************************************************************
  // Bus phases
  // ****************************************************************
  // Eight cycles a phase, twice the slave's minimum
  localparam int HALF = 8;

  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic hold();
    repeat (HALF) @(posedge sys_clk_i);
  endtask

  task automatic start();
    sda_o <= 1'b0;
    hold();
    scl_o <= 1'b0;
    hold();
  endtask

  // Given in the ack slot it aborts the read
  task automatic stop();
    sda_o <= 1'b0;
    hold();
    scl_o <= 1'b1;
    hold();
    sda_o <= 1'b1;
    hold();
  endtask

  task automatic xfer(input logic b, output logic r);
    sda_o <= b;
    hold();
    scl_o <= 1'b1;
    hold();
    r = sda_i;
    scl_o <= 1'b0;
    hold();
  endtask

  task automatic addr(input logic [7:0] a, output logic ack);
    logic r;
    start();
    for (int i = 7; i >= 0; i--) xfer(a[i], r);
    xfer(1'b1, r);
    ack = ~r;
  endtask

  // Without mack the ack slot is left to the caller
  task automatic rd(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
    if (mack) xfer(1'b0, r);
  endtask
endmodule // acs_i2c_mst

`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the conversion sequencer.
// Assumes shortened reset, conversion and timeout counts and a 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // ****************************************************************
  // Clock, pins and counters
  // ****************************************************************
  localparam int POR  = 50;
  localparam int CONV = 600;
  localparam int TMO  = 40;
  localparam int DEC  = acs_pkg::DEC_EXT_PER;
  logic        sys_clk_i   = 1'b0;
  logic        arst_n_i    = 1'b0;
  logic        supply_ok_i = 1'b1;
  logic [1:0]  hi_code     = 2'h2;
  logic        lo_flt      = 1'b1;
  logic        lo_lvl      = 1'b0;
  logic        lo_pin      = 1'b0;
  logic        ext_on      = 1'b0;
  logic        ext_cnt     = 1'b0;
  logic [23:0] result      = 24'hA53C96;
  wire         scl, sda_m, sda_o, sda_oe_n, osc, cal, dec;
  wire  [1:0]  seq;
  wire         sda = sda_m & (sda_oe_n | sda_o);
  int          miscompares = 0;
  int          compares    = 0;
  int          cal_cnt     = 0;

  always #2.5 sys_clk_i = ~sys_clk_i;

  // External clock of period 4 cycles, inside the detection timeout
  always @(posedge sys_clk_i) begin
    ext_cnt <= ~ext_cnt;
    if (!ext_on) lo_pin <= lo_lvl;
    else if (ext_cnt) lo_pin <= ~lo_pin;
    if (cal === 1'b1) cal_cnt++;
  end

  acs_sequencer #(.POR_CYC(POR), .CONV_INT_CYC(CONV), .EXT_TMO_CYC(TMO)) u_dut (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .supply_ok_i(supply_ok_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
    .addr_strap_high_pin_i(hi_code), .addr_strap_low_clock_pin_i(lo_pin),
    .addr_strap_low_float_i(lo_flt), .conv_result_i(result), .osc_enable_o(osc),
    .seq_state_o(seq), .cal_start_o(cal), .dec_tick_o(dec));
  acs_i2c_mst u_mst (.sys_clk_i(sys_clk_i), .sda_i(sda), .scl_o(scl), .sda_o(sda_m));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_seq(input logic [1:0] s, input int lim, output int n);
    n = 0;
    while (seq !== s) begin
      @(posedge sys_clk_i);
      n++;
      if (n > lim) begin
        miscompares++;
        $display("ERROR seq_wait expected %h seen %h", s, seq);
        test_done();
      end
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic sc_reset();
    int n;
    check("rst_oe_n", sda_oe_n, 1'b1);
    check("rst_osc", osc, 1'b1);
    check("rst_seq", seq, 2'h0);
    arst_n_i <= 1'b1;
    wait_seq(2'h1, POR + 20, n);
    check("por_len", n >= POR, 1'b1);
    wait_seq(2'h2, CONV + 20, n);
    check("conv_len", n >= CONV - 2 && n <= CONV + 2, 1'b1);
    check("cal_cnt", cal_cnt, 1);
    supply_ok_i <= 1'b0;
    wait_seq(2'h0, 8, n);
    supply_ok_i <= 1'b1;
    wait_seq(2'h1, POR + 20, n);
    check("por_again", n >= POR, 1'b1);
  endtask

  task automatic sc_busy();
    logic ack;
    int   n;
    u_mst.addr({acs_pkg::ADDR_FF, acs_pkg::RW_READ}, ack);
    check("busy_ack", ack, 1'b0);
    u_mst.stop();
    wait_seq(2'h2, CONV + 20, n);
    u_mst.addr({acs_pkg::ADDR_FF, 1'b0}, ack);
    check("write_ack", ack, 1'b0);
    u_mst.stop();
    check("write_seq", seq, 2'h2);
  endtask

  task automatic sc_read();
    logic       ack;
    logic [7:0] b0, b1, b2;
    int         c;
    c = cal_cnt;
    u_mst.addr({acs_pkg::ADDR_FF, acs_pkg::RW_READ}, ack);
    check("rd_ack", ack, 1'b1);
    check("rd_seq", seq, 2'h3);
    u_mst.rd(1'b1, b0);
    u_mst.rd(1'b1, b1);
    u_mst.rd(1'b0, b2);
    check("rd_data", {b0, b1, b2}, 24'hA53C96);
    check("rd_end", seq, 2'h1);
    u_mst.stop();
    u_mst.addr({acs_pkg::ADDR_FF, acs_pkg::RW_READ}, ack);
    check("reread_ack", ack, 1'b0);
    u_mst.stop();
    check("rd_cal", cal_cnt, c + 1);
  endtask

  task automatic sc_straps();
    logic [3:0] cfg [4] = '{4'h9, 4'hA, 4'h5, 4'h6};
    logic [6:0] adr [4] = '{acs_pkg::ADDR_FH, acs_pkg::ADDR_FF, acs_pkg::ADDR_HH,
                            acs_pkg::ADDR_HF};
    logic       ack;
    logic [7:0] b;
    int         n;
    for (int i = 0; i < 4; i++) begin
      {hi_code, lo_flt, lo_lvl} <= cfg[i];
      result <= {5'h00, adr[i], 12'hABC};
      wait_seq(2'h2, CONV + 20, n);
      u_mst.addr({adr[i], acs_pkg::RW_READ}, ack);
      check("strap_ack", ack, 1'b1);
      u_mst.rd(1'b0, b);
      check("strap_byte", b, result[23:16]);
      u_mst.stop();
      check("abort_seq", seq, 2'h1);
    end
  endtask

  task automatic sc_ext();
    logic       ack;
    logic [7:0] b;
    int         n;
    wait_seq(2'h2, CONV + 20, n);
    hi_code <= acs_pkg::LVL_HIGH;
    lo_flt <= 1'b0;
    ext_on <= 1'b1;
    repeat (60) @(posedge sys_clk_i);
    check("ext_osc", osc, 1'b0);
    // One frame strobe per 5120 external periods of 4 cycles
    n = 0;
    while (dec !== 1'b1 && n <= 4 * DEC) begin
      @(posedge sys_clk_i);
      n++;
    end
    check("dec_gap", n >= 4 * DEC - 80 && n <= 4 * DEC, 1'b1);
    if (n > 4 * DEC) test_done();
    check("ext_seq", seq, 2'h2);
    u_mst.addr({acs_pkg::ADDR_HH, acs_pkg::RW_READ}, ack);
    check("ext_ack", ack, 1'b1);
    u_mst.rd(1'b0, b);
    check("ext_byte", b, result[23:16]);
    u_mst.stop();
    ext_on <= 1'b0;
    repeat (TMO + 6) @(posedge sys_clk_i);
    check("int_osc", osc, 1'b1);
    wait_seq(2'h2, CONV + 20, n);
  endtask

  initial begin
    repeat (12) @(posedge sys_clk_i);
    sc_reset();
    sc_busy();
    sc_read();
    sc_straps();
    sc_ext();
    test_done();
  end
endmodule // tb_top

`default_nettype wire
